/* rtl/dac_output_update_reset_control.sv */
// update, clear, reset and monitor control of an octal 12-bit converter
// Contract
// - clear low grounds outputs, buffers off
// - loads ignored in clear; release waits strobe
// - strobe tied low: release restores latches
// - clear leaves all registers and latches unchanged
// - power-on loads select-defined values and defaults
// - input data registers reset to zero
// - dual-supply reset codes by select and format
// - single supply: offset off, same code mapping
// - hardware reset applies select-defined reset values
// - hardware reset blocks bus, data bus floats
// - after reset hold values, resume bus
// - update mode latched from strobe at power-on
// - load updates only channels written since load
// - async mode: update on select rise, engine off
// - async engine on: update when engine writes
// - sync: strobe fall or soft load updates written channels
// - sync load during busy deferred until idle
// - sync: no load means latches unchanged
// - monitor routes one source, else floats
// - engine running sets busy flag, pulls pin
`default_nettype none
module dac_output_update_reset_control
   import upd_ctl_pkg::*;
(
   // clock and power-on reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // pins from the host
   input wire logic output_clear_n,
   input wire logic hw_reset_n,
   input wire logic load_strobe_n,
   input wire logic reset_level_select,
   input wire logic data_format_select,
   input wire logic single_supply,
   // bus front end, same clock
   input wire logic reg_write,
   input wire logic [2:0] write_chan,
   input wire logic [11:0] write_data,
   input wire logic select_rise,
   input wire logic soft_load_bit,
   input wire logic correction_enable,
   input wire logic [11:0] monitor_reg_in,
   input wire logic monitor_reg_wr,
   // correction engine, same clock
   input wire logic engine_run,
   input wire logic engine_done,
   input wire logic [2:0] engine_chan,
   input wire logic [11:0] engine_data,
   // outputs
   output logic [NUM_CH*CODE_W-1:0] latch_codes,
   output logic [NUM_CH*CODE_W-1:0] data_regs,
   output logic [NUM_CH*CODE_W-1:0] input_regs,
   output logic [NUM_CH*CODE_W-1:0] gain_regs,
   output logic [NUM_CH*CODE_W-1:0] zero_regs,
   output logic [11:0] offset_code,
   output logic output_ground,
   output logic output_buf_en,
   output logic bus_enable,
   output logic data_bus_oe,
   output logic async_mode,
   output logic correction_busy_flag,
   output logic busy_pin_o,
   output logic busy_pin_oe,
   output logic monitor_oe,
   output var mon_src_t monitor_src,
   output logic [2:0] monitor_chan
);
   logic [1:0] clr_sync_ff;
   logic [1:0] sel_sync_ff, fmt_sync_ff, sup_sync_ff, settle_ff;
   logic [1:0] rst_sync_ff;
   logic [2:0] ld_sync_ff;
   logic clr_n_s, hrst_n_s, ld_n_s, ld_fall;
   logic mode_taken_ff, async_ff;
   logic cleared_ff, busy_ff, defer_ff;
   logic [NUM_CH-1:0] dirty_ff;
   logic [CODE_W-1:0] latch_ff [NUM_CH];
   logic [CODE_W-1:0] data_ff [NUM_CH];
   logic [CODE_W-1:0] input_ff [NUM_CH];
   logic [CODE_W-1:0] gain_ff [NUM_CH];
   logic [CODE_W-1:0] zero_ff [NUM_CH];
   logic [11:0] ofs_ff, mon_ff;
   logic [11:0] rst_code;
   logic bus_ok, sync_load, load_all;

   // reset code table, select inverts for twos complement
   function automatic logic [11:0] reset_code(input logic sel, input logic fmt);
      reset_code = (sel ^ fmt) ? CODE_MID : CODE_ZERO;
   endfunction

   // pins are asynchronous to clk_sys; first stage read only by second
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clr_sync_ff <= 2'h0;
         rst_sync_ff <= 2'h0;
         ld_sync_ff <= 3'h7;
      end
      else
      begin
         clr_sync_ff <= {clr_sync_ff[0], output_clear_n};
         rst_sync_ff <= {rst_sync_ff[0], hw_reset_n};
         ld_sync_ff <= {ld_sync_ff[1:0], load_strobe_n};
      end
   end

   // straps are static pins but still cross into clk_sys
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_sync_ff <= 2'h0;
         fmt_sync_ff <= 2'h0;
         sup_sync_ff <= 2'h0;
      end
      else
      begin
         sel_sync_ff <= {sel_sync_ff[0], reset_level_select};
         fmt_sync_ff <= {fmt_sync_ff[0], data_format_select};
         sup_sync_ff <= {sup_sync_ff[0], single_supply};
      end
   end

   // reset values of the sync flops mean nothing until they have filled
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         settle_ff <= 2'h0;
      else if (settle_ff != POR_SETTLE)
         settle_ff <= settle_ff + 2'h1;
   end

   assign clr_n_s = clr_sync_ff[1];
   assign hrst_n_s = rst_sync_ff[1];
   assign ld_n_s = ld_sync_ff[1];
   assign ld_fall = ld_sync_ff[2] & ~ld_sync_ff[1];
   assign rst_code = reset_code(sel_sync_ff[1], fmt_sync_ff[1]);
   assign bus_ok = hrst_n_s;

   // mode caught once after power-on release, not in the async reset
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_taken_ff <= 1'b0;
         async_ff <= ~MODE_RESET_SYNC;
      end
      else if (!mode_taken_ff && settle_ff == POR_SETTLE)
      begin
         mode_taken_ff <= 1'b1;
         async_ff <= ~ld_n_s;
      end
   end

   // engine busy flag follows the engine's run level
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         busy_ff <= 1'b0;
      else if (!hrst_n_s)
         busy_ff <= 1'b0;
      else
         busy_ff <= engine_run & correction_enable;
   end

   // sync load request; a busy engine defers it to the flag's fall
   assign sync_load = !async_ff && clr_n_s && bus_ok && mode_taken_ff
      && (ld_fall || (reg_write == 1'b0 && soft_load_bit));
   assign load_all = (sync_load && !(correction_enable && busy_ff))
      || (defer_ff && !busy_ff);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         defer_ff <= 1'b0;
      else if (!hrst_n_s)
         defer_ff <= 1'b0;
      else if (sync_load && correction_enable && busy_ff)
         defer_ff <= 1'b1;
      else if (!busy_ff)
         defer_ff <= 1'b0;
   end

   // clear state: released with strobe high waits for a strobe fall
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         cleared_ff <= 1'b1;
      else if (!clr_n_s)
         cleared_ff <= 1'b1;
      else if (!ld_n_s)
         cleared_ff <= 1'b0;
   end

   // per-channel registers; clear touches none of them
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            input_ff[i] <= CODE_ZERO;
            data_ff[i] <= CODE_ZERO;
            latch_ff[i] <= CODE_ZERO;
            gain_ff[i] <= GAIN_DEFAULT;
            zero_ff[i] <= ZERO_DEFAULT;
         end
         dirty_ff <= '0;
      end
      else if (!hrst_n_s || !mode_taken_ff)
      begin
         // power-on finishes here too, once pins are sampled
         for (int i = 0; i < NUM_CH; i++)
         begin
            input_ff[i] <= CODE_ZERO;
            data_ff[i] <= rst_code;
            latch_ff[i] <= rst_code;
            gain_ff[i] <= GAIN_DEFAULT;
            zero_ff[i] <= ZERO_DEFAULT;
         end
         dirty_ff <= '0;
      end
      else
      begin
         // clear reaches these branches only through sync_load in load_all
         // load first so a write in the same cycle keeps its dirty bit
         if (load_all)
         begin
            for (int i = 0; i < NUM_CH; i++)
               if (dirty_ff[i])
                  latch_ff[i] <= data_ff[i];
            dirty_ff <= '0;
         end
         if (bus_ok && reg_write)
         begin
            if (correction_enable)
               input_ff[write_chan] <= write_data;
            else
               data_ff[write_chan] <= write_data;
            if (!async_ff)
               dirty_ff[write_chan] <= 1'b1;
         end
         if (engine_done && correction_enable)
         begin
            data_ff[engine_chan] <= engine_data;
            if (async_ff)
               latch_ff[engine_chan] <= engine_data;
            else
               dirty_ff[engine_chan] <= 1'b1;
         end
         // async, engine off: latch follows on select rise
         if (async_ff && !correction_enable && select_rise && bus_ok)
            latch_ff[write_chan] <= data_ff[write_chan];
      end
   end

   // offset code; single supply switches the offset converter off
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         ofs_ff <= OFS_OFF;
      else if (!hrst_n_s || !mode_taken_ff)
      begin
         if (sup_sync_ff[1])
            ofs_ff <= OFS_OFF;
         else if (fmt_sync_ff[1])
            ofs_ff <= OFS_TC_G6;
         else
            ofs_ff <= OFS_SB_G6;
      end
   end

   // monitor register; a hardware reset disables monitoring
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         mon_ff <= MON_RESET;
      else if (!hrst_n_s)
         mon_ff <= MON_RESET;
      else if (monitor_reg_wr)
         mon_ff <= monitor_reg_in;
   end

   // lowest set channel bit wins; with no channel bit, offset A, offset B, reference A, reference B in that order
   always_comb
   begin
      monitor_src = MON_NONE;
      monitor_chan = 3'h0;
      for (int i = NUM_CH - 1; i >= 0; i--)
         if (mon_ff[MON_CH_LSB + i])
         begin
            monitor_src = MON_CHAN;
            monitor_chan = 3'(i);
         end
      if (monitor_src == MON_NONE)
      begin
         if (mon_ff[MON_OFS_A])
            monitor_src = MON_OFSA;
         else if (mon_ff[MON_OFS_B])
            monitor_src = MON_OFSB;
         else if (mon_ff[MON_REF_A])
            monitor_src = MON_REFA;
         else if (mon_ff[MON_REF_B])
            monitor_src = MON_REFB;
      end
   end

   assign monitor_oe = (monitor_src != MON_NONE);

   always_comb
   begin
      for (int i = 0; i < NUM_CH; i++)
      begin
         latch_codes[i*CODE_W +: CODE_W] = latch_ff[i];
         data_regs[i*CODE_W +: CODE_W] = data_ff[i];
         input_regs[i*CODE_W +: CODE_W] = input_ff[i];
         gain_regs[i*CODE_W +: CODE_W] = gain_ff[i];
         zero_regs[i*CODE_W +: CODE_W] = zero_ff[i];
      end
   end

   // ground and buffer state, glitch free as both come from flops
   assign output_ground = cleared_ff;
   assign output_buf_en = ~cleared_ff;
   assign bus_enable = bus_ok & mode_taken_ff;
   assign data_bus_oe = 1'b0;
   assign offset_code = ofs_ff;
   assign async_mode = async_ff;
   assign correction_busy_flag = busy_ff;
   assign busy_pin_o = 1'b0;
   assign busy_pin_oe = busy_ff;
endmodule // dac_output_update_reset_control
`default_nettype wire

/* rtl/upd_ctl_pkg.sv */
// constants for the converter update, clear and reset control
package upd_ctl_pkg;
   localparam int unsigned NUM_CH = 8;
   localparam int unsigned CODE_W = 12;
   localparam int unsigned MON_W = 12;
   localparam logic [11:0] CODE_ZERO = 12'h000;
   localparam logic [11:0] CODE_MID = 12'h800;
   localparam logic [11:0] OFS_SB_G6 = 12'h99a;
   localparam logic [11:0] OFS_TC_G6 = 12'h19a;
   localparam logic [11:0] OFS_OFF = 12'h000;
   localparam logic [11:0] GAIN_DEFAULT = 12'hfff;
   localparam logic [11:0] ZERO_DEFAULT = 12'h000;
   localparam logic [11:0] MON_RESET = 12'h000;
   localparam logic MODE_RESET_SYNC = 1'b1;
   // edges after power-on release until the second sync flop holds the pins
   localparam logic [1:0] POR_SETTLE = 2'h2;
   // monitor register field positions
   localparam int unsigned MON_CH_LSB = 4;
   localparam int unsigned MON_OFS_A = 3;
   localparam int unsigned MON_OFS_B = 2;
   localparam int unsigned MON_REF_A = 1;
   localparam int unsigned MON_REF_B = 0;
   typedef enum logic [2:0] {
      MON_NONE,
      MON_CHAN,
      MON_OFSA,
      MON_OFSB,
      MON_REFA,
      MON_REFB
   } mon_src_t;
endpackage

/* tb/host_pins.sv */
// host side model driving the clear, reset and load strobe pins
`default_nettype none
module host_pins (
   // clock and pins
   input wire logic clk_sys,
   output var logic output_clear_n,
   output var logic hw_reset_n,
   output var logic load_strobe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      output_clear_n = 1'b1;
      hw_reset_n = 1'b1;
      load_strobe_n = 1'b1;
   end
   // pins move just after an edge, then hold for n cycles
   task automatic pin(input int k, input logic v, input int n);
      @(posedge clk_sys);
      if (k == 0)
         output_clear_n <= v;
      else if (k == 1)
         hw_reset_n <= v;
      else
         load_strobe_n <= v;
      repeat (n) @(posedge clk_sys);
   endtask
endmodule // host_pins
`default_nettype wire

/* tb/upd_ctl_monitor.sv */
// assertion checker on the update control ports
`default_nettype none
module upd_ctl_monitor (
   // clock, reset and pins
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic output_clear_n,
   input wire logic hw_reset_n,
   input wire logic load_strobe_n,
   input wire logic soft_load_bit,
   input wire logic reg_write,
   // outputs
   input wire logic [95:0] latch_codes,
   input wire logic [95:0] data_regs,
   input wire logic [95:0] input_regs,
   input wire logic output_ground,
   input wire logic output_buf_en,
   input wire logic bus_enable,
   input wire logic async_mode,
   input wire logic correction_busy_flag,
   input wire logic busy_pin_o,
   input wire logic busy_pin_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] quiet_ff;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // synced strobe lags the pin, so wait until no late fall can land
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         quiet_ff <= 3'h0;
      else
         quiet_ff <= (!load_strobe_n || !hw_reset_n) ? 3'h0 : quiet_ff + 3'(quiet_ff != 3'h7);
   end
   property p_float; output_ground |-> !output_buf_en; endproperty
   a_float: assert property (p_float) else $error("buffer on while grounded");
   property p_clr; !output_clear_n [*4] |-> output_ground; endproperty
   a_clr: assert property (p_clr) else $error("clear did not ground outputs");
   property p_busy; busy_pin_oe == correction_busy_flag && !busy_pin_o; endproperty
   a_busy: assert property (p_busy) else $error("busy pin not following flag");
   property p_mode; $rose(rst_n) |-> ##3 async_mode == !load_strobe_n; endproperty
   a_mode: assert property (p_mode) else $error("update mode taken wrongly");
   property p_hold;
      !async_mode && quiet_ff == 3'h7 && !$past(soft_load_bit) && !$past(correction_busy_flag)
      && !$past(correction_busy_flag, 2) |-> $stable(latch_codes);
   endproperty
   a_hold: assert property (p_hold) else $error("latch moved without load");
   property p_load;
      !async_mode && bus_enable && !output_ground && output_clear_n && soft_load_bit
      && !reg_write && !correction_busy_flag |=> latch_codes == $past(data_regs);
   endproperty
   a_load: assert property (p_load) else $error("soft load missed data");
   property p_defer; !async_mode && correction_busy_flag && soft_load_bit |=> $stable(latch_codes);
   endproperty
   a_defer: assert property (p_defer) else $error("load not deferred");
   property p_hwrst; !hw_reset_n [*4] |-> !bus_enable && input_regs == '0; endproperty
   a_hwrst: assert property (p_hwrst) else $error("hardware reset not applied");
   c_soft: cover property (soft_load_bit && !async_mode);
   c_defer: cover property ($fell(correction_busy_flag));
   c_async: cover property (async_mode && reg_write);
endmodule // upd_ctl_monitor
bind dac_output_update_reset_control upd_ctl_monitor u_mon (.*);
`default_nettype wire

/* tb/dac_output_update_reset_control_bench.sv */
// self-checking bench for the update, clear and reset control
`default_nettype none
module dac_output_update_reset_control_bench
   import upd_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, rst_n, reset_level_select, data_format_select, single_supply, engine_run;
   logic reg_write, select_rise, soft_load_bit, correction_enable, monitor_reg_wr, engine_done;
   logic [2:0] write_chan, engine_chan, monitor_chan;
   logic [11:0] write_data, engine_data, monitor_reg_in, offset_code;
   logic [95:0] latch_codes, data_regs, input_regs, gain_regs, zero_regs;
   logic output_ground, output_buf_en, bus_enable, data_bus_oe, async_mode;
   logic correction_busy_flag, busy_pin_o, busy_pin_oe, monitor_oe;
   mon_src_t monitor_src;
   wire logic output_clear_n, hw_reset_n, load_strobe_n;
   int n_errors, n_compared;
   host_pins hp (.clk_sys, .output_clear_n, .hw_reset_n, .load_strobe_n);
   dac_output_update_reset_control DUT (.*);
   function automatic logic [11:0] ch(input logic [95:0] v, input int i);
      return v[12*i +: 12];
   endfunction
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one-cycle strobe of kind k, then room for the answer to land
   task automatic pul(input int k);
      @(posedge clk_sys);
      case (k)
         0: reg_write <= 1'b1;
         1: select_rise <= 1'b1;
         2: soft_load_bit <= 1'b1;
         3: engine_done <= 1'b1;
         default: monitor_reg_wr <= 1'b1;
      endcase
      @(posedge clk_sys);
      {reg_write, select_rise, soft_load_bit, engine_done, monitor_reg_wr} <= 5'h0;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic wrt(input logic [2:0] c, input logic [11:0] d);
      write_chan <= c;
      write_data <= d;
      pul(0);
   endtask
   task automatic rv(input logic s, input logic f, input logic u);
      {reset_level_select, data_format_select, single_supply} <= {s, f, u};
      hp.pin(1, 1'b0, 5);
      chk("bus_enable", 12'h000, 12'(bus_enable));
      hp.pin(1, 1'b1, 4);
      chk("latch7", (s ^ f) ? CODE_MID : CODE_ZERO, ch(latch_codes, 7));
      chk("input3", CODE_ZERO, ch(input_regs, 3));
      chk("offset", u ? OFS_OFF : (f ? OFS_TC_G6 : OFS_SB_G6), offset_code);
      chk("gain5", GAIN_DEFAULT, ch(gain_regs, 5));
      chk("zero2", ZERO_DEFAULT, ch(zero_regs, 2));
      chk("bus_oe", 12'h000, 12'(data_bus_oe));
   endtask
   task automatic mon(input logic [11:0] v, input mon_src_t s);
      monitor_reg_in <= v;
      pul(4);
      chk("mon_src", 12'(s), 12'(monitor_src));
      chk("mon_oe", 12'(s != MON_NONE), 12'(monitor_oe));
   endtask
   task automatic summarize;
      $display("compared %0d mismatched %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // run needs well under a thousand cycles
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      n_errors++;
      summarize();
   end
   initial
   begin
      {rst_n, single_supply, data_format_select, reset_level_select} = 4'h1;
      {reg_write, select_rise, soft_load_bit, correction_enable, engine_run} = 5'h0;
      {monitor_reg_wr, engine_done, write_chan, engine_chan} = 8'h0;
      {write_data, engine_data, monitor_reg_in} = 36'h0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("mode", 12'h000, 12'(async_mode));
      chk("latch0", CODE_MID, ch(latch_codes, 0));
      chk("offset", OFS_SB_G6, offset_code);
      chk("ground", 12'h001, 12'(output_ground));
      hp.pin(2, 1'b0, 5);
      hp.pin(2, 1'b1, 5);
      chk("ground", 12'h000, 12'(output_ground));
      for (int i = 0; i < 8; i++)
         rv(i[2], i[1], i[0]);
      $display("test resets done");
      wrt(3'h3, 12'h5a5);
      repeat (8) @(posedge clk_sys);
      chk("held3", CODE_ZERO, ch(latch_codes, 3));
      pul(2);
      chk("load3", 12'h5a5, ch(latch_codes, 3));
      hp.pin(0, 1'b0, 5);
      chk("buf_en", 12'h000, 12'(output_buf_en));
      wrt(3'h3, 12'h0f0);
      pul(2);
      chk("clear3", 12'h5a5, ch(latch_codes, 3));
      hp.pin(0, 1'b1, 5);
      chk("ground", 12'h001, 12'(output_ground));
      hp.pin(2, 1'b0, 5);
      chk("strobe3", 12'h0f0, ch(latch_codes, 3));
      hp.pin(2, 1'b1, 3);
      $display("test load and clear done");
      correction_enable <= 1'b1;
      engine_run <= 1'b1;
      {engine_chan, engine_data} <= {3'h5, 12'h321};
      pul(3);
      chk("busy", 12'h001, 12'(correction_busy_flag));
      pul(2);
      chk("defer5", CODE_ZERO, ch(latch_codes, 5));
      engine_run <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk("late5", 12'h321, ch(latch_codes, 5));
      mon(12'h040, MON_CHAN);
      chk("mon_chan", 12'h002, 12'(monitor_chan));
      mon(12'h008, MON_OFSA);
      mon(12'h001, MON_REFB);
      mon(12'h000, MON_NONE);
      $display("test busy and monitor done");
      hp.pin(2, 1'b0, 0);
      {rst_n, correction_enable} <= 2'h0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk("mode", 12'h001, 12'(async_mode));
      wrt(3'h2, 12'h777);
      pul(1);
      chk("cs2", 12'h777, ch(latch_codes, 2));
      wrt(3'h4, 12'h444);
      pul(2);
      chk("nocs4", CODE_ZERO, ch(latch_codes, 4));
      hp.pin(0, 1'b0, 5);
      hp.pin(0, 1'b1, 5);
      chk("ground", 12'h000, 12'(output_ground));
      chk("keep2", 12'h777, ch(latch_codes, 2));
      correction_enable <= 1'b1;
      {engine_chan, engine_data} <= {3'h6, 12'h606};
      pul(3);
      chk("engine6", 12'h606, ch(latch_codes, 6));
      $display("test async done");
      summarize();
   end
endmodule // dac_output_update_reset_control_bench
`default_nettype wire
